// ===== logic/rss_pkg.sv
// ****************************************
// Shared constants for the strap sampler
// ****************************************
package rss_pkg;
    // Core clock period and strap sampling delay
    localparam int unsigned CLK_PERIOD_NS   = 8;
    localparam int unsigned STRAP_DELAY_NS  = 1500;
    // Least time: round up to whole cycles
    localparam int unsigned STRAP_DELAY_CYC =
        (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DELAY_CNT_W     = 12;
    // Bit positions of the debug data bus
    localparam int unsigned DBG_SPREAD_BIT  = 0;
    localparam int unsigned DBG_MAND_BIT    = 1;
    localparam int unsigned DBG_FOUR_BIT    = 2;
    localparam int unsigned DBG_SEVEN_BIT   = 3;
    localparam int unsigned DBG_W           = 4;
    // Reset values of the captured straps (pulldown default)
    localparam logic        SPREAD_RST      = 1'b0;
    localparam logic        MAND_RST        = 1'b0;
endpackage : rss_pkg

// ===== logic/rss_timer_if.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Timer to sampler handshake
// ****************************************
interface rss_timer_if;
    logic sample_pulse;   // One cycle at the sampling point
    logic elapsed;        // Level, high once sampling has passed
    modport timer   (output sample_pulse, output elapsed);
    modport sampler (input sample_pulse, input elapsed);
endinterface : rss_timer_if
`default_nettype wire

// ===== logic/rss_delay_timer.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Post-reset delay to the strap sampling point
// ****************************************
module rss_delay_timer #(
    parameter int unsigned DELAY_CYC = rss_pkg::STRAP_DELAY_CYC
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    rss_timer_if.timer  tmr
);
    localparam int unsigned W = rss_pkg::DELAY_CNT_W;
    localparam logic [W-1:0] LAST = W'(DELAY_CYC - 1);

    logic [W-1:0] cnt_reg;
    logic         done_reg;
    logic         pulse_reg;

    // Counts core clocks from reset release, then stops for good
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (!done_reg && cnt_reg != LAST) begin
            cnt_reg <= cnt_reg + 1'b1;                     // [RULE_02]
        end
    end

    // Single sampling pulse; done blocks any second one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_reg  <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= !done_reg && cnt_reg == LAST;     // [RULE_02]
            if (cnt_reg == LAST) begin
                done_reg <= 1'b1;
            end
        end
    end

    assign tmr.sample_pulse = pulse_reg;
    assign tmr.elapsed      = done_reg;
endmodule : rss_delay_timer
`default_nettype wire

// ===== logic/rss_strap_sampler.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Overview of operation
// [RULE_01] Strap pins stay undriven while reset is held low.
// [RULE_02] Each strap is sampled once about 1.5 us after reset release.
// [RULE_03] Spread strap 0 disables spread spectrum; 1 uses flash settings.
// [RULE_04] Pins become debug outputs only after their sampling point.
// [RULE_05] Undriven spread strap reads 0 through pulldown, disabling spreading.
// [RULE_06] Board must hold the mandatory-high strap high at sampling.
// [RULE_07] Board holds test pins four and seven low or open.
// [RULE_08] Board ties the factory test enable permanently low.
// [RULE_09] Captured straps hold until the next reset, ignoring later pin activity.
module rss_strap_sampler #(
    parameter int unsigned DELAY_CYC = rss_pkg::STRAP_DELAY_CYC
) (
    input  wire logic                     REF_CLK,
    input  wire logic                     RESETN,
    input  wire logic                     SPREAD_DISABLE_STRAP_IN,
    output logic                          SPREAD_DISABLE_STRAP_OUT,
    output logic                          SPREAD_DISABLE_STRAP_OE,
    input  wire logic                     MANDATORY_HIGH_STRAP_IN,
    output logic                          MANDATORY_HIGH_STRAP_OUT,
    output logic                          MANDATORY_HIGH_STRAP_OE,
    input  wire logic                     TEST_PIN_FOUR_IN,
    output logic                          TEST_PIN_FOUR_OUT,
    output logic                          TEST_PIN_FOUR_OE,
    input  wire logic                     TEST_PIN_SEVEN_IN,
    output logic                          TEST_PIN_SEVEN_OUT,
    output logic                          TEST_PIN_SEVEN_OE,
    input  wire logic                     FACTORY_TEST_ENABLE,
    input  wire logic                     DEBUG_ENABLE,
    input  wire logic [rss_pkg::DBG_W-1:0] DEBUG_DATA,
    output logic                          STRAPS_VALID,
    output logic                          SPREAD_ENABLE,
    output logic                          MANDATORY_HIGH_OK,
    output logic                          TEST_PINS_LOW,
    output logic                          FACTORY_TEST_ACTIVE
);
    // ****************************************
    // Sampling point timer
    // ****************************************
    // Counter kept apart so a bench can shorten the delay
    rss_timer_if tmr_if ();

    rss_delay_timer #(
        .DELAY_CYC (DELAY_CYC)
    ) u_timer (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .tmr   (tmr_if.timer)
    );

    // ****************************************
    // Capture guard
    // ****************************************
    logic valid_reg;
    logic capture_now;

    // Second guard beside the timer: at most one capture per reset
    assign capture_now = tmr_if.sample_pulse && !valid_reg;   // [RULE_09]

    // Capture flag; only reset clears it again
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            valid_reg <= 1'b0;
        end else if (capture_now) begin
            valid_reg <= 1'b1;                                // [RULE_02]
        end
    end

    // ****************************************
    // Spread spectrum strap
    // ****************************************
    logic spread_reg;

    // Reset value matches the pulldown default of an open pin
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            spread_reg <= rss_pkg::SPREAD_RST;                // [RULE_05]
        end else if (capture_now) begin
            spread_reg <= SPREAD_DISABLE_STRAP_IN;            // [RULE_03]
        end
    end

    // ****************************************
    // Mandatory-high strap
    // ****************************************
    logic mand_reg;

    // A low capture is only reported; the board has to fix it,
    // since the pulldown alone would give the wrong level
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            mand_reg <= rss_pkg::MAND_RST;
        end else if (capture_now) begin
            mand_reg <= MANDATORY_HIGH_STRAP_IN;              // [RULE_02]
        end
    end

    // ****************************************
    // Test pins four and seven
    // ****************************************
    logic low_reg;

    // Both must read low at capture for normal operation
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            low_reg <= 1'b0;
        end else if (capture_now) begin
            low_reg <= !TEST_PIN_FOUR_IN && !TEST_PIN_SEVEN_IN; // [RULE_07]
        end
    end
    // No branch without a capture: later pin activity is ignored [RULE_09]

    // ****************************************
    // Factory test input
    // ****************************************
    logic ftest_reg;

    // Factory test input is only reported, never acted on
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ftest_reg <= 1'b0;
        end else begin
            ftest_reg <= FACTORY_TEST_ENABLE;                 // [RULE_08]
        end
    end

    // ****************************************
    // Debug output drive
    // ****************************************
    logic dbg_on;

    // Drive needs the request, a passed sampling point and a capture
    assign dbg_on = DEBUG_ENABLE && tmr_if.elapsed && valid_reg; // [RULE_04]

    // Enables start low and rise only after capture, so a strap is
    // never fought by our own driver while the board presents it
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            SPREAD_DISABLE_STRAP_OE <= 1'b0;                  // [RULE_01]
        end else begin
            SPREAD_DISABLE_STRAP_OE <= dbg_on;                // [RULE_04]
        end
    end

    // Mandatory-high pin: same gate as the spread pin
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            MANDATORY_HIGH_STRAP_OE <= 1'b0;                  // [RULE_01]
        end else begin
            MANDATORY_HIGH_STRAP_OE <= dbg_on;                // [RULE_04]
        end
    end

    // Pin four carries no strap, but shares the gate for simplicity
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            TEST_PIN_FOUR_OE <= 1'b0;
        end else begin
            TEST_PIN_FOUR_OE <= dbg_on;                       // [RULE_04]
        end
    end

    // Pin seven: as pin four
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            TEST_PIN_SEVEN_OE <= 1'b0;
        end else begin
            TEST_PIN_SEVEN_OE <= dbg_on;                      // [RULE_04]
        end
    end

    // ****************************************
    // Debug output data
    // ****************************************
    // Spread pin data; runs while undriven so drive starts clean
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            SPREAD_DISABLE_STRAP_OUT <= 1'b0;
        end else begin
            SPREAD_DISABLE_STRAP_OUT <= DEBUG_DATA[rss_pkg::DBG_SPREAD_BIT];
        end
    end

    // Mandatory-high pin data
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            MANDATORY_HIGH_STRAP_OUT <= 1'b0;
        end else begin
            MANDATORY_HIGH_STRAP_OUT <= DEBUG_DATA[rss_pkg::DBG_MAND_BIT];
        end
    end

    // Pin four data
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            TEST_PIN_FOUR_OUT <= 1'b0;
        end else begin
            TEST_PIN_FOUR_OUT <= DEBUG_DATA[rss_pkg::DBG_FOUR_BIT];
        end
    end

    // Pin seven data
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            TEST_PIN_SEVEN_OUT <= 1'b0;
        end else begin
            TEST_PIN_SEVEN_OUT <= DEBUG_DATA[rss_pkg::DBG_SEVEN_BIT];
        end
    end

    // ****************************************
    // Status outputs
    // ****************************************
    // Status flags wired straight from their flops; FACTORY_TEST_ACTIVE follows its pin every cycle
    assign STRAPS_VALID        = valid_reg;
    assign SPREAD_ENABLE       = spread_reg;                  // [RULE_03]
    assign MANDATORY_HIGH_OK   = mand_reg;
    assign TEST_PINS_LOW       = low_reg;
    assign FACTORY_TEST_ACTIVE = ftest_reg;
endmodule : rss_strap_sampler
`default_nettype wire

// ===== dv/rss_board.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Board side of the strap pins
// ****
module rss_board (
    input  wire logic [3:0] dev_out,
    input  wire logic [3:0] dev_oe,
    input  wire logic [3:0] ext_en,
    input  wire logic [3:0] ext_val,
    output logic      [3:0] pin,
    output logic            test_en
);
    // Device drive wins, else host level, else the weak pulldown reads 0
    assign pin = (dev_oe & dev_out) | (~dev_oe & ext_en & ext_val);
    assign test_en = 1'b0; // Factory test tied off
endmodule : rss_board
`default_nettype wire

// ===== dv/rss_strap_sampler_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Strap sampler checks
// ****
module rss_strap_sampler_assertions #(parameter int unsigned DELAY_CYC = 4) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic SPREAD_DISABLE_STRAP_IN,
    input wire logic MANDATORY_HIGH_STRAP_IN,
    input wire logic SPREAD_DISABLE_STRAP_OE,
    input wire logic MANDATORY_HIGH_STRAP_OE,
    input wire logic TEST_PIN_FOUR_OE,
    input wire logic TEST_PIN_SEVEN_OE,
    input wire logic DEBUG_ENABLE,
    input wire logic STRAPS_VALID,
    input wire logic SPREAD_ENABLE,
    input wire logic MANDATORY_HIGH_OK
);
    logic [7:0] cnt_reg;
    wire  [3:0] oe = {TEST_PIN_SEVEN_OE, TEST_PIN_FOUR_OE, MANDATORY_HIGH_STRAP_OE,
                      SPREAD_DISABLE_STRAP_OE};
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    // Edges since release; saturates so long runs never wrap
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) cnt_reg <= 8'h00;
        else if (cnt_reg != 8'hff) cnt_reg <= cnt_reg + 8'h01;
    end
    early_valid_a: assert property (
        cnt_reg <= DELAY_CYC |-> !STRAPS_VALID) else $error("capture too early");
    capture_time_a: assert property (
        cnt_reg == DELAY_CYC + 1 |-> STRAPS_VALID) else $error("capture too late");
    spread_capture_a: assert property (
        $rose(STRAPS_VALID) |-> SPREAD_ENABLE == $past(SPREAD_DISABLE_STRAP_IN))
        else $error("spread strap wrong");
    mand_capture_a: assert property (
        $rose(STRAPS_VALID) |-> MANDATORY_HIGH_OK == $past(MANDATORY_HIGH_STRAP_IN))
        else $error("mandatory strap wrong");
    debug_gate_a: assert property (
        !STRAPS_VALID |-> oe == 4'h0) else $error("pin driven before capture");
    debug_follow_a: assert property (
        STRAPS_VALID && DEBUG_ENABLE |=> oe == 4'hf) else $error("debug drive missing");
    debug_off_a: assert property (
        !DEBUG_ENABLE |=> oe == 4'h0) else $error("debug drive stuck");
    values_hold_a: assert property (
        STRAPS_VALID |=> STRAPS_VALID && $stable(SPREAD_ENABLE) && $stable(MANDATORY_HIGH_OK))
        else $error("captured straps moved");
    cover property ($rose(STRAPS_VALID) && SPREAD_ENABLE);
    cover property ($rose(STRAPS_VALID) && !SPREAD_ENABLE);
    cover property (STRAPS_VALID && oe == 4'hf);
endmodule : rss_strap_sampler_assertions
bind rss_strap_sampler rss_strap_sampler_assertions #(.DELAY_CYC(DELAY_CYC)) chk_inst (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .SPREAD_DISABLE_STRAP_IN(SPREAD_DISABLE_STRAP_IN),
    .MANDATORY_HIGH_STRAP_IN(MANDATORY_HIGH_STRAP_IN), .TEST_PIN_FOUR_OE(TEST_PIN_FOUR_OE),
    .SPREAD_DISABLE_STRAP_OE(SPREAD_DISABLE_STRAP_OE), .TEST_PIN_SEVEN_OE(TEST_PIN_SEVEN_OE),
    .MANDATORY_HIGH_STRAP_OE(MANDATORY_HIGH_STRAP_OE), .DEBUG_ENABLE(DEBUG_ENABLE),
    .STRAPS_VALID(STRAPS_VALID), .SPREAD_ENABLE(SPREAD_ENABLE),
    .MANDATORY_HIGH_OK(MANDATORY_HIGH_OK));
`default_nettype wire

// ===== dv/reset_strap_sampler_test.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Strap sampler bench
// ****
module reset_strap_sampler_test;
    localparam int unsigned D = 4; // Short delay keeps each boot brief
    logic       ref_clk, resetn, dbg_en, test_en, valid, spread, mand, low, fact;
    logic [3:0] dbg_data, ext_en, ext_val, dout, doe, pin;
    int         num_errors = 0;
    int         checked = 0;
    logic [7:0] cases [4] = '{8'h00, 8'hf3, 8'hf6, 8'h5d}; // Host enables, then levels
    rss_board rss_board_inst (.dev_out(dout), .dev_oe(doe), .ext_en(ext_en),
        .ext_val(ext_val), .pin(pin), .test_en(test_en));
    rss_strap_sampler #(.DELAY_CYC(D)) rss_strap_sampler_inst (.REF_CLK(ref_clk),
        .RESETN(resetn), .SPREAD_DISABLE_STRAP_IN(pin[0]), .SPREAD_DISABLE_STRAP_OUT(dout[0]),
        .SPREAD_DISABLE_STRAP_OE(doe[0]), .MANDATORY_HIGH_STRAP_IN(pin[1]),
        .MANDATORY_HIGH_STRAP_OUT(dout[1]), .MANDATORY_HIGH_STRAP_OE(doe[1]),
        .TEST_PIN_FOUR_IN(pin[2]), .TEST_PIN_FOUR_OUT(dout[2]), .TEST_PIN_FOUR_OE(doe[2]),
        .TEST_PIN_SEVEN_IN(pin[3]), .TEST_PIN_SEVEN_OUT(dout[3]), .TEST_PIN_SEVEN_OE(doe[3]),
        .FACTORY_TEST_ENABLE(test_en), .DEBUG_ENABLE(dbg_en), .DEBUG_DATA(dbg_data),
        .STRAPS_VALID(valid), .SPREAD_ENABLE(spread), .MANDATORY_HIGH_OK(mand),
        .TEST_PINS_LOW(low), .FACTORY_TEST_ACTIVE(fact));
    task check(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : check
    // One reset, capture, late pin upset and debug drive
    task boot(input logic [3:0] en, input logic [3:0] val);
        logic [3:0] p;
        p = en & val; // Undriven pins read low
        @(posedge ref_clk);
        {resetn, ext_en, ext_val, dbg_en, dbg_data} <= {1'b0, en, val, en[0], val ^ 4'h5};
        #1 check(doe, 4'h0);
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (D) begin
            @(posedge ref_clk);
            #1 check({doe[3:1], valid}, 4'h0);
        end
        @(posedge ref_clk);
        #1 check({valid, spread, mand, low}, {1'b1, p[0], p[1], ~(p[2] | p[3])});
        check({doe[2:0], fact}, 4'h0);
        @(posedge ref_clk);
        {ext_en, ext_val} <= {4'hf, ~val}; // Upset the pins after capture
        repeat (3) @(posedge ref_clk);
        #1 check({valid, spread, mand, low}, {1'b1, p[0], p[1], ~(p[2] | p[3])});
        check(doe & dout, {4{en[0]}} & (val ^ 4'h5));
        check(doe, {4{en[0]}});
        check(dout, val ^ 4'h5);
    endtask : boot
    task tally_and_finish;
        if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Main sequence: every strap combination in the table
    initial begin
        {resetn, dbg_en, dbg_data, ext_en, ext_val} = '0;
        repeat (3) @(posedge ref_clk);
        foreach (cases[i]) boot(cases[i][7:4], cases[i][3:0]);
        tally_and_finish();
    end
    // Watchdog far beyond four boots of thirteen cycles
    initial begin
        repeat (1000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish();
    end
endmodule : reset_strap_sampler_test
`default_nettype wire
